//--- core/rgb_pkg.sv
package rgb_pkg;

	localparam logic [7:0] ADDR_WRITE = 8'h70;
	localparam int SEL_MSB = 7;
	localparam int SEL_LSB = 5;
	localparam int PAY_MSB = 4;
	localparam int STEP_W = 5;
	localparam int DUTY_W = 5;

	localparam logic [2:0] SEL_SHUTDOWN = 3'h0;
	localparam logic [2:0] SEL_PEAK = 3'h1;
	localparam logic [2:0] SEL_DUTY1 = 3'h2;
	localparam logic [2:0] SEL_DUTY2 = 3'h3;
	localparam logic [2:0] SEL_DUTY3 = 3'h4;
	localparam logic [2:0] SEL_UP = 3'h5;
	localparam logic [2:0] SEL_DOWN = 3'h6;
	localparam logic [2:0] SEL_RUN = 3'h7;

	localparam logic [4:0] STEP_RESET = 5'h00;
	localparam logic [4:0] DUTY_RESET = 5'h00;
	localparam logic [4:0] STEP_TOP = 5'h1f;
	localparam logic [4:0] STEP_MAX_LEVEL = 5'h1e;

	localparam int CLK_HZ = 10_000_000;
	localparam int MS_TIME_MS = 1;
	localparam int MS_CYCLES = CLK_HZ / 1000 * MS_TIME_MS;
	localparam int STEP_UNIT_MS = 8;
	localparam int PWM_FREQ_HZ = 2100;
	localparam int PWM_LEVELS = 32;
	localparam int PWM_TICK_CYCLES = CLK_HZ / (PWM_FREQ_HZ * PWM_LEVELS);

	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_ADDR = 5'h02,
		ST_ACK_ADDR = 5'h04,
		ST_CMD = 5'h08,
		ST_ACK_CMD = 5'h10
	} rgb_state_t;

endpackage

//--- core/rgb_pwm_channel.sv
`timescale 1ns/1ps
`default_nettype none
module rgb_pwm_channel #(
	parameter int WIDTH = rgb_pkg::DUTY_W
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic tick,
	input wire logic [WIDTH-1:0] duty,
	output logic led_on
);
	logic [WIDTH-1:0] cnt;
	logic [WIDTH-1:0] next_cnt;
	logic next_led_on;

	// Zero is dark, all ones is steady on, others modulate
	always_comb
	begin
		next_cnt = tick ? WIDTH'(cnt + 1'b1) : cnt;
		if (duty == {WIDTH{1'b1}})
			next_led_on = 1'b1;
		else
			next_led_on = (cnt < duty);
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			cnt <= '0;
			led_on <= 1'b0;
		end
		else
		begin
			cnt <= next_cnt;
			led_on <= next_led_on;
		end
	end

	property p_duty_off;
		@(posedge clk) disable iff (srst)
		(duty == '0) |=> !led_on;
	endproperty
	a_duty_off: assert property (p_duty_off) else $error("Zero duty lit the LED");

	property p_duty_full;
		@(posedge clk) disable iff (srst)
		(duty == {WIDTH{1'b1}}) |=> led_on;
	endproperty
	a_duty_full: assert property (p_duty_full) else $error("Full duty left LED dark");

	property p_duty_ratio;
		@(posedge clk) disable iff (srst)
		(duty != {WIDTH{1'b1}}) |=> (led_on == ($past(cnt) < $past(duty)));
	endproperty
	a_duty_ratio: assert property (p_duty_ratio) else $error("PWM ratio wrong");

endmodule // rgb_pwm_channel
`default_nettype wire

//--- core/rgb_cmd_decoder.sv
// Operation
// - Frame holds address byte then command byte
// - Answer only to address byte 70 hex
// - Top three bits select, low five payload
// - Selector 000 shuts down, payload ignored
// - Selector 001 stores shared peak step code
// - Peak step applies directly, no ramp
// - Selector 101 stores upward target, sets up direction, no start
// - Selector 110 stores downward target, sets down direction, no start
// - Selector 111 stores dwell, starts ramp
// - Step code zero forces zero current
// - Step codes 30 and 31 equal maximum
// - Ramp time is dwell times steps
// - Each duty channel has 32 levels
// - Step count is absolute position difference
// - Duty zero off, 1F fully on
// - Ramp starts at command byte acknowledge
`timescale 1ns/1ps
`default_nettype none
module rgb_cmd_decoder #(
	parameter int MS_CYCLES = rgb_pkg::MS_CYCLES,
	parameter int PWM_TICK_CYCLES = rgb_pkg::PWM_TICK_CYCLES
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic scl,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_n,
	output logic [4:0] led_output_current,
	output logic [2:0] led_on,
	output logic ramp_busy
);
	localparam int MSW = $clog2(MS_CYCLES + 1);
	localparam int PWW = $clog2(PWM_TICK_CYCLES + 1);

	function automatic logic [4:0] step_dist(input logic [4:0] a, input logic [4:0] b);
		step_dist = (a > b) ? 5'(a - b) : 5'(b - a);
	endfunction

	// Pin synchronisers, level accepted once stages two and three agree
	logic [2:0] scl_sync;
	logic [2:0] sda_sync;
	logic scl_f;
	logic sda_f;
	logic scl_prev;
	logic sda_prev;
	logic next_scl_f;
	logic next_sda_f;

	always_comb
	begin
		next_scl_f = (scl_sync[1] == scl_sync[2]) ? scl_sync[2] : scl_f;
		next_sda_f = (sda_sync[1] == sda_sync[2]) ? sda_sync[2] : sda_f;
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			scl_sync <= 3'h7;
			sda_sync <= 3'h7;
			scl_f <= 1'b1;
			sda_f <= 1'b1;
			scl_prev <= 1'b1;
			sda_prev <= 1'b1;
		end
		else
		begin
			scl_sync <= {scl_sync[1:0], scl};
			sda_sync <= {sda_sync[1:0], sda_in};
			scl_f <= next_scl_f;
			sda_f <= next_sda_f;
			scl_prev <= scl_f;
			sda_prev <= sda_f;
		end
	end

	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;
	assign scl_rise = scl_f & ~scl_prev;
	assign scl_fall = ~scl_f & scl_prev;
	assign start_det = sda_prev & ~sda_f & scl_f & scl_prev;
	assign stop_det = ~sda_prev & sda_f & scl_f & scl_prev;
	assign sda_out = 1'b0;

	// Serial receiver
	rgb_pkg::rgb_state_t state;
	rgb_pkg::rgb_state_t next_state;
	logic [3:0] bit_cnt;
	logic [3:0] next_bit_cnt;
	logic [7:0] shreg;
	logic [7:0] next_shreg;
	logic next_sda_oe_n;
	logic cmd_stb;
	logic next_cmd_stb;
	logic [7:0] cmd_byte;
	logic [7:0] next_cmd_byte;

	always_comb
	begin
		next_state = state;
		next_bit_cnt = bit_cnt;
		next_shreg = shreg;
		next_sda_oe_n = sda_oe_n;
		next_cmd_stb = 1'b0;
		next_cmd_byte = cmd_byte;
		if (start_det)
		begin
			next_state = rgb_pkg::ST_ADDR;
			next_bit_cnt = 4'h0;
			next_sda_oe_n = 1'b1;
		end
		else if (stop_det)
		begin
			next_state = rgb_pkg::ST_IDLE;
			next_sda_oe_n = 1'b1;
		end
		else
		begin
			case (state)
				rgb_pkg::ST_ADDR, rgb_pkg::ST_CMD:
				begin
					if (scl_rise && bit_cnt != 4'h8)
					begin
						next_shreg = {shreg[6:0], sda_f};
						next_bit_cnt = 4'(bit_cnt + 1'b1);
					end
					else if (scl_fall && bit_cnt == 4'h8)
					begin
						if (state == rgb_pkg::ST_CMD)
						begin
							next_sda_oe_n = 1'b0;
							next_cmd_stb = 1'b1;
							next_cmd_byte = shreg;
							next_state = rgb_pkg::ST_ACK_CMD;
						end
						else if (shreg == rgb_pkg::ADDR_WRITE)
						begin
							next_sda_oe_n = 1'b0;
							next_state = rgb_pkg::ST_ACK_ADDR;
						end
						else
							next_state = rgb_pkg::ST_IDLE;
					end
				end
				rgb_pkg::ST_ACK_ADDR:
				begin
					if (scl_fall)
					begin
						next_sda_oe_n = 1'b1;
						next_bit_cnt = 4'h0;
						next_state = rgb_pkg::ST_CMD;
					end
				end
				rgb_pkg::ST_ACK_CMD:
				begin
					if (scl_fall)
					begin
						next_sda_oe_n = 1'b1;
						next_state = rgb_pkg::ST_IDLE;
					end
				end
				default:
				begin
				end
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			state <= rgb_pkg::ST_IDLE;
			bit_cnt <= 4'h0;
			shreg <= 8'h00;
			sda_oe_n <= 1'b1;
			cmd_stb <= 1'b0;
			cmd_byte <= 8'h00;
		end
		else
		begin
			state <= next_state;
			bit_cnt <= next_bit_cnt;
			shreg <= next_shreg;
			sda_oe_n <= next_sda_oe_n;
			cmd_stb <= next_cmd_stb;
			cmd_byte <= next_cmd_byte;
		end
	end

	// Command registers and dimming ramp
	logic [2:0] sel;
	logic [4:0] payload;
	assign sel = cmd_byte[rgb_pkg::SEL_MSB:rgb_pkg::SEL_LSB];
	assign payload = cmd_byte[rgb_pkg::PAY_MSB:0];

	logic [4:0] cur_step, next_cur_step;
	logic [4:0] duty [3];
	logic [4:0] next_duty [3];
	logic [4:0] up_target, next_up_target;
	logic [4:0] down_target, next_down_target;
	logic [4:0] step_time, next_step_time;
	logic dir_down, next_dir_down;
	logic next_ramp_busy;
	logic [4:0] steps_left, next_steps_left;
	logic [7:0] ms_cnt, next_ms_cnt;
	logic [MSW-1:0] ms_div, next_ms_div;
	logic [PWW-1:0] pwm_div, next_pwm_div;
	logic ms_tick;
	logic pwm_tick;
	logic [4:0] target;
	logic [7:0] dwell_ms;
	logic step_due;
	logic [4:0] next_led_output_current;

	assign ms_tick = (ms_div == MSW'(MS_CYCLES - 1));
	assign pwm_tick = (pwm_div == PWW'(PWM_TICK_CYCLES - 1));
	assign target = dir_down ? down_target : up_target;
	assign dwell_ms = 8'(step_time * 8'(rgb_pkg::STEP_UNIT_MS));
	assign step_due = ramp_busy && ms_tick && (8'(ms_cnt + 1'b1) >= dwell_ms);

	always_comb
	begin
		next_cur_step = cur_step;
		next_duty = duty;
		next_up_target = up_target;
		next_down_target = down_target;
		next_step_time = step_time;
		next_dir_down = dir_down;
		next_ramp_busy = ramp_busy;
		next_steps_left = steps_left;
		next_ms_cnt = ms_cnt;
		next_ms_div = ms_tick ? '0 : MSW'(ms_div + 1'b1);
		next_pwm_div = pwm_tick ? '0 : PWW'(pwm_div + 1'b1);
		if (ramp_busy && ms_tick)
			next_ms_cnt = step_due ? 8'h00 : 8'(ms_cnt + 1'b1);
		if (step_due)
		begin
			next_cur_step = (cur_step < target) ? 5'(cur_step + 1'b1) : 5'(cur_step - 1'b1);
			next_steps_left = 5'(steps_left - 1'b1);
			if (steps_left == 5'h01)
				next_ramp_busy = 1'b0;
		end
		if (cmd_stb)
		begin
			if (sel == rgb_pkg::SEL_SHUTDOWN)
			begin
				next_cur_step = rgb_pkg::STEP_RESET;
				next_ramp_busy = 1'b0;
			end
			else if (sel == rgb_pkg::SEL_PEAK)
			begin
				next_cur_step = payload;
				next_ramp_busy = 1'b0;
			end
			else if (sel == rgb_pkg::SEL_DUTY1)
				next_duty[0] = payload;
			else if (sel == rgb_pkg::SEL_DUTY2)
				next_duty[1] = payload;
			else if (sel == rgb_pkg::SEL_DUTY3)
				next_duty[2] = payload;
			else if (sel == rgb_pkg::SEL_UP)
			begin
				next_up_target = payload;
				next_dir_down = 1'b0;
			end
			else if (sel == rgb_pkg::SEL_DOWN)
			begin
				next_down_target = payload;
				next_dir_down = 1'b1;
			end
			else
			begin
				next_step_time = payload;
				next_cur_step = cur_step;
				next_steps_left = step_dist(cur_step, target);
				next_ramp_busy = (cur_step != target);
				next_ms_cnt = 8'h00;
				next_ms_div = '0;
			end
		end
		if (cur_step == rgb_pkg::STEP_RESET)
			next_led_output_current = 5'h00;
		else if (cur_step == rgb_pkg::STEP_TOP)
			next_led_output_current = rgb_pkg::STEP_MAX_LEVEL;
		else
			next_led_output_current = cur_step;
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			cur_step <= rgb_pkg::STEP_RESET;
			duty <= '{default: rgb_pkg::DUTY_RESET};
			up_target <= rgb_pkg::STEP_RESET;
			down_target <= rgb_pkg::STEP_RESET;
			step_time <= 5'h00;
			dir_down <= 1'b0;
			ramp_busy <= 1'b0;
			steps_left <= 5'h00;
			ms_cnt <= 8'h00;
			ms_div <= '0;
			pwm_div <= '0;
			led_output_current <= 5'h00;
		end
		else
		begin
			cur_step <= next_cur_step;
			duty <= next_duty;
			up_target <= next_up_target;
			down_target <= next_down_target;
			step_time <= next_step_time;
			dir_down <= next_dir_down;
			ramp_busy <= next_ramp_busy;
			steps_left <= next_steps_left;
			ms_cnt <= next_ms_cnt;
			ms_div <= next_ms_div;
			pwm_div <= next_pwm_div;
			led_output_current <= next_led_output_current;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++)
		begin : g_pwm
			rgb_pwm_channel #(.WIDTH(rgb_pkg::DUTY_W)) u_pwm (
				.clk(clk),
				.srst(srst),
				.tick(pwm_tick),
				.duty(duty[gi]),
				.led_on(led_on[gi])
			);
		end
	endgenerate

	property p_addr_reject;
		@(posedge clk) disable iff (srst)
		(state == rgb_pkg::ST_ADDR && scl_fall && bit_cnt == 4'h8 && !start_det && !stop_det
			&& shreg != rgb_pkg::ADDR_WRITE) |=> sda_oe_n && state == rgb_pkg::ST_IDLE;
	endproperty
	a_addr_reject: assert property (p_addr_reject) else $error("Foreign or read address acked");

	property p_ack_only_after_byte;
		@(posedge clk) disable iff (srst)
		$fell(sda_oe_n) |-> $past(bit_cnt) == 4'h8
			&& ($past(state) == rgb_pkg::ST_CMD || $past(shreg) == rgb_pkg::ADDR_WRITE);
	endproperty
	a_ack_only_after_byte: assert property (p_ack_only_after_byte) else $error("Stray ack");

	property p_shutdown;
		@(posedge clk) disable iff (srst)
		(cmd_stb && sel == rgb_pkg::SEL_SHUTDOWN) |=> cur_step == 5'h00 && !ramp_busy
			##1 led_output_current == 5'h00;
	endproperty
	a_shutdown: assert property (p_shutdown) else $error("Shutdown did not zero current");

	property p_peak_direct;
		@(posedge clk) disable iff (srst)
		(cmd_stb && sel == rgb_pkg::SEL_PEAK) |=> cur_step == $past(payload) && !ramp_busy;
	endproperty
	a_peak_direct: assert property (p_peak_direct) else $error("Peak step not applied");

	property p_duty_load;
		@(posedge clk) disable iff (srst)
		(cmd_stb && sel == rgb_pkg::SEL_DUTY2) |=> duty[1] == $past(payload)
			&& $stable(duty[0]) && $stable(duty[2]);
	endproperty
	a_duty_load: assert property (p_duty_load) else $error("Duty load crossed channels");

	property p_target_no_start;
		@(posedge clk) disable iff (srst)
		(cmd_stb && (sel == rgb_pkg::SEL_UP || sel == rgb_pkg::SEL_DOWN) && !ramp_busy)
			|=> !ramp_busy;
	endproperty
	a_target_no_start: assert property (p_target_no_start) else $error("Target started ramp");

	property p_run_start;
		@(posedge clk) disable iff (srst)
		(cmd_stb && sel == rgb_pkg::SEL_RUN) |=> ramp_busy == ($past(cur_step) != $past(target))
			&& steps_left == step_dist($past(cur_step), $past(target));
	endproperty
	a_run_start: assert property (p_run_start) else $error("Ramp start wrong");

	property p_one_step;
		@(posedge clk) disable iff (srst)
		(step_due && !cmd_stb) |=> step_dist(cur_step, $past(cur_step)) == 5'h01;
	endproperty
	a_one_step: assert property (p_one_step) else $error("Ramp step not one code");

	property p_level_map;
		@(posedge clk) disable iff (srst)
		(cur_step == 5'h00 || cur_step == rgb_pkg::STEP_TOP) |=>
			led_output_current == (($past(cur_step) == 5'h00) ? 5'h00 : rgb_pkg::STEP_MAX_LEVEL);
	endproperty
	a_level_map: assert property (p_level_map) else $error("Level mapping wrong");

	c_addr_ack: cover property (@(posedge clk) disable iff (srst)
		state == rgb_pkg::ST_ACK_ADDR ##[1:400] cmd_stb);
	c_ramp_done: cover property (@(posedge clk) disable iff (srst) $fell(ramp_busy));
	c_shutdown: cover property (@(posedge clk) disable iff (srst)
		cmd_stb && sel == rgb_pkg::SEL_SHUTDOWN);

endmodule // rgb_cmd_decoder
`default_nettype wire

//--- bench/rgb_i2c_master.sv
`timescale 1ns/1ps
`default_nettype none
module rgb_i2c_master (
	output logic scl,
	output logic sda_line,
	input wire logic sda_out,
	input wire logic sda_oe_n
);
	logic drv = 1'b1;
	initial scl = 1'b1;
	// Pulled-up wire: low when either side pulls it
	assign sda_line = drv & (sda_oe_n | sda_out);
	// Long low phase so the filtered ack edges land before the filtered rise
	task automatic bit_cyc(input logic b, output logic seen);
		#300 drv = b;
		#300 scl = 1'b1;
		#100 seen = sda_line;
		#100 scl = 1'b0;
	endtask
	// One frame of n bytes; ack[i] high if byte i was acknowledged
	task automatic frame(input logic [7:0] a, input logic [7:0] c, input logic [7:0] x,
		input int n, output logic [2:0] ack);
		logic [7:0] b [3];
		logic s;
		b[0] = a;
		b[1] = c;
		b[2] = x;
		ack = 3'h0;
		#400 drv = 1'b0;
		#400 scl = 1'b0;
		for (int i = 0; i < n; i++)
		begin
			for (int k = 7; k >= 0; k--)
				bit_cyc(b[i][k], s);
			bit_cyc(1'b1, s);
			ack[i] = ~s;
		end
		#200 drv = 1'b0;
		#200 scl = 1'b1;
		#400 drv = 1'b1;
		#400;
	endtask
endmodule // rgb_i2c_master
`default_nettype wire

//--- bench/test_rgb_cmd_decoder.sv
`timescale 1ns/1ps
`default_nettype none
module test_rgb_cmd_decoder;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic scl, sda_line, sda_out, sda_oe_n, ramp_busy;
	logic [4:0] led_output_current, prev_cur, s;
	logic [4:0] dv [3];
	logic [2:0] led_on, ack;
	logic [31:0] rs = 32'd98799;
	int fail_count = 0;
	int num_checks = 0;
	int busy_cnt = 0;
	int b0;
	int on_cnt [3];
	always #50 clk = ~clk;
	rgb_cmd_decoder #(.MS_CYCLES(10), .PWM_TICK_CYCLES(2)) rgb_cmd_decoder_inst (
		.clk(clk), .srst(srst), .scl(scl), .sda_in(sda_line), .sda_out(sda_out),
		.sda_oe_n(sda_oe_n), .led_output_current(led_output_current), .led_on(led_on),
		.ramp_busy(ramp_busy));
	rgb_i2c_master rgb_i2c_master_inst (.scl(scl), .sda_line(sda_line), .sda_out(sda_out),
		.sda_oe_n(sda_oe_n));
	function automatic logic [31:0] xs(input logic [31:0] v);
		v ^= v << 13;
		v ^= v >> 17;
		v ^= v << 5;
		return v;
	endfunction
	function automatic logic [4:0] exp_cur(input logic [4:0] c);
		return (c == 5'h1f) ? 5'h1e : c;
	endfunction
	task automatic check_val(input string nm, input logic [4:0] e, input logic [4:0] g);
		num_checks++;
		if (g !== e)
		begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic check_cnt(input string nm, input int e, input int g);
		num_checks++;
		if (g != e)
		begin
			fail_count++;
			$display("MISMATCH %s expected %0d seen %0d", nm, e, g);
		end
	endtask
	task automatic test_done;
		if (fail_count == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic send(input logic [7:0] a, input logic [2:0] sel, input logic [4:0] p,
		input int n);
		@(negedge clk);
		rgb_i2c_master_inst.frame(a, {sel, p}, rs[7:0], n, ack);
		rs = xs(rs);
		repeat (4) @(negedge clk);
	endtask
	task automatic ramp(input int exp_len, input logic [4:0] tgt);
		for (int t = 0; t < 3000 && ramp_busy !== 1'b0; t++)
			@(negedge clk);
		repeat (2) @(negedge clk);
		check_cnt("ramp_len", exp_len / 8, (busy_cnt - b0 + 4) / 8);
		check_val("ramp_end", tgt, led_output_current);
	endtask
	always @(posedge clk)
		busy_cnt <= busy_cnt + ((ramp_busy === 1'b1) ? 1 : 0);
	always @(negedge clk)
	begin
		if (ramp_busy === 1'b1 && led_output_current !== prev_cur)
			check_cnt("ramp_step", 1, (led_output_current > prev_cur) ?
				int'(led_output_current - prev_cur) : int'(prev_cur - led_output_current));
		prev_cur <= led_output_current;
	end
	initial
	begin
		#2_000_000;
		fail_count++;
		test_done;
	end
	initial
	begin
		repeat (5) @(negedge clk);
		srst = 1'b0;
		repeat (4) @(negedge clk);
		send(8'h71, rgb_pkg::SEL_PEAK, 5'h1f, 2);
		check_val("ack_read", 5'h00, {2'b00, ack});
		send(8'h72, rgb_pkg::SEL_PEAK, 5'h1f, 2);
		check_val("ack_other", 5'h00, {2'b00, ack});
		check_val("cur_other", 5'h00, led_output_current);
		for (int i = 0; i < 10; i++)
		begin
			s = (i == 0) ? 5'h1f : (i == 1) ? 5'h1e : (i == 2) ? 5'h00 : rs[12:8];
			send({7'h38, 1'b0}, rgb_pkg::SEL_PEAK, s, 3);
			check_val("ack", 5'h03, {2'b00, ack});
			check_val("cur", exp_cur(s), led_output_current);
			check_val("busy", 5'h00, {4'h0, ramp_busy});
		end
		send(8'h70, rgb_pkg::SEL_PEAK, 5'h14, 2);
		send(8'h70, rgb_pkg::SEL_SHUTDOWN, rs[4:0] | 5'h10, 2);
		check_val("cur_off", 5'h00, led_output_current);
		dv[0] = 5'h00;
		dv[1] = 5'h1f;
		dv[2] = rs[20:16];
		for (int k = 0; k < 3; k++)
		begin
			send(8'h70, rgb_pkg::SEL_DUTY1 + 3'(k), dv[k], 2);
			on_cnt[k] = 0;
		end
		repeat (64)
		begin
			@(negedge clk);
			for (int k = 0; k < 3; k++)
				on_cnt[k] += (led_on[k] === 1'b1) ? 1 : 0;
		end
		for (int k = 0; k < 3; k++)
			check_cnt("duty_on", (dv[k] == 5'h1f) ? 64 : 2 * dv[k], on_cnt[k]);
		send(8'h70, rgb_pkg::SEL_PEAK, 5'h05, 2);
		send(8'h70, rgb_pkg::SEL_UP, 5'h0f, 2);
		check_val("up_held", 5'h05, led_output_current);
		check_val("up_idle", 5'h00, {4'h0, ramp_busy});
		b0 = busy_cnt;
		send(8'h70, rgb_pkg::SEL_RUN, 5'h01, 2);
		ramp(10 * 80, 5'h0f);
		send(8'h70, rgb_pkg::SEL_DOWN, 5'h0c, 2);
		check_val("down_idle", 5'h00, {4'h0, ramp_busy});
		b0 = busy_cnt;
		send(8'h70, rgb_pkg::SEL_RUN, 5'h02, 2);
		ramp(3 * 160, 5'h0c);
		send(8'h70, rgb_pkg::SEL_UP, 5'h14, 2);
		send(8'h70, rgb_pkg::SEL_RUN, 5'h01, 2);
		send(8'h70, rgb_pkg::SEL_PEAK, 5'h07, 2);
		check_val("abort_busy", 5'h00, {4'h0, ramp_busy});
		check_val("abort_cur", 5'h07, led_output_current);
		test_done;
	end
endmodule // test_rgb_cmd_decoder
`default_nettype wire
